/* File: common/asp_pkg.sv */
// Purpose: shared constants and types for the arithmetic status and pointer mode block
// Assumes: 8-bit core datapath, 32-bit AXI4-Lite register bus
// Notes: byte offsets, field positions, reset values and encodings live here only
package asp_pkg;
    // register byte offsets
    localparam logic [7:0] ASP_STATUS_OFFS = 8'h04;
    localparam logic [7:0] ASP_PTR0_OFFS = 8'h08;
    localparam logic [7:0] ASP_PTR1_OFFS = 8'h0C;
    // field positions inside arith_status
    localparam int ASP_PTR1_MODE_LSB = 6;
    localparam int ASP_PTR0_MODE_LSB = 4;
    localparam int ASP_OV_BIT = 3;
    localparam int ASP_Z_BIT = 2;
    localparam int ASP_DC_BIT = 1;
    localparam int ASP_C_BIT = 0;
    // reset values: both pointers hold, flags cleared
    localparam logic [7:0] ASP_STATUS_RST = 8'hF0;
    localparam logic [7:0] ASP_PTR_RST = 8'h00;
    // pointer step mode codes, upper bit set means hold
    localparam logic [1:0] ASP_STEP_DEC = 2'h0;
    localparam logic [1:0] ASP_STEP_INC = 2'h1;
    // bus responses
    localparam logic [1:0] ASP_RESP_OKAY = 2'h0;
    localparam logic [1:0] ASP_RESP_SLVERR = 2'h2;
    // alu operations
    typedef enum logic [2:0] {
        ASP_OP_ADD = 3'h0,
        ASP_OP_SUB = 3'h1,
        ASP_OP_AND = 3'h2,
        ASP_OP_OR = 3'h3,
        ASP_OP_XOR = 3'h4,
        ASP_OP_MOV = 3'h5,
        ASP_OP_RLC = 3'h6,
        ASP_OP_RRC = 3'h7
    } asp_op_t;
    // one alu request from the core
    typedef struct packed {
        logic valid;
        asp_op_t op;
        logic [7:0] a;
        logic [7:0] b;
    } asp_alu_req_t;
    // registered alu answer
    typedef struct packed {
        logic valid;
        logic [7:0] data;
    } asp_alu_rsp_t;
endpackage : asp_pkg

/* File: design/asp_core.sv */
// Purpose: arithmetic status flags and indirect pointer step control with AXI4-Lite access
// Assumes: single clock aclk, synchronous active-low reset, core inputs on the same clock
// Notes: one alu request per cycle, answer and flags one edge later
// Summary of operation
// RQ1: status bits 7:6 select pointer one step
// RQ2: status bits 5:4 select pointer zero step
// RQ3: overflow flag marks wrong signed sign change
// RQ4: zero flag marks zero arithmetic or logic result
// RQ5: add sets nibble carry from bit three
// RQ6: add sets carry from most significant bit
// RQ7: borrow gives carry flags inverted meaning
// RQ8: subtraction adds two's complement of operand
// RQ9: rotates load carry with shifted-out bit
// RQ10: pointer steps only after its indirect access
//
// Decided for this implementation: the AXI4-Lite register port.
module asp_core
    import asp_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write address
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // axi4-lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read address
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // axi4-lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // core alu port
    input wire asp_alu_req_t alu_req,
    output asp_alu_rsp_t alu_rsp,
    // indirect access completion, bit 0 pointer zero, bit 1 pointer one
    input wire logic [1:0] ptr_access_done,
    // pointer and status views for the core
    output logic [7:0] indirect_pointer_zero,
    output logic [7:0] indirect_pointer_one,
    output logic [7:0] arith_status
);

    // ---------------- bus write side ----------------
    logic aw_held; // write address captured
    logic w_held; // write data captured
    logic [ADDR_W-1:0] aw_addr; // captured address
    logic [31:0] w_data; // captured data
    logic [3:0] w_strb; // captured strobes

    // each channel is free while nothing of it is held and no response waits
    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready = !w_held && !s_axi_bvalid;

    wire aw_take = s_axi_awvalid && s_axi_awready;
    wire w_take = s_axi_wvalid && s_axi_wready;
    wire wr_fire = aw_held && w_held; // both halves present, commit now
    wire [7:0] wr_addr8 = 8'(aw_addr);
    wire wr_low = w_strb[0]; // only byte lane 0 carries data
    wire wr_status = wr_fire && wr_low && (wr_addr8 == ASP_STATUS_OFFS);
    wire wr_ptr0 = wr_fire && wr_low && (wr_addr8 == ASP_PTR0_OFFS);
    wire wr_ptr1 = wr_fire && wr_low && (wr_addr8 == ASP_PTR1_OFFS);
    wire wr_mapped = (wr_addr8 == ASP_STATUS_OFFS) || (wr_addr8 == ASP_PTR0_OFFS)
        || (wr_addr8 == ASP_PTR1_OFFS);

    // capture address and data in either order, respond after both
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= '0;
            w_data <= 32'h00000000;
            w_strb <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= ASP_RESP_OKAY;
        end else begin
            if (aw_take) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (w_take) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (wr_fire) begin
                // commit and raise the response
                aw_held <= 1'b0;
                w_held <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_mapped ? ASP_RESP_OKAY : ASP_RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0; // response taken
            end
        end
    end

    // ---------------- bus read side ----------------
    assign s_axi_arready = !s_axi_rvalid;
    wire ar_take = s_axi_arvalid && s_axi_arready;
    wire [7:0] rd_addr8 = 8'(s_axi_araddr);
    wire rd_status = (rd_addr8 == ASP_STATUS_OFFS);
    wire rd_ptr0 = (rd_addr8 == ASP_PTR0_OFFS);
    wire rd_ptr1 = (rd_addr8 == ASP_PTR1_OFFS);
    wire [7:0] rd_byte = rd_status ? arith_status
        : rd_ptr0 ? indirect_pointer_zero
        : rd_ptr1 ? indirect_pointer_one : 8'h00;
    wire rd_mapped = rd_status || rd_ptr0 || rd_ptr1;

    // one read answered the edge after its address is taken
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= ASP_RESP_OKAY;
        end else if (ar_take) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= {24'h000000, rd_byte};
            s_axi_rresp <= rd_mapped ? ASP_RESP_OKAY : ASP_RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0; // data taken
        end
    end

    // ---------------- alu datapath ----------------
    wire is_add = alu_req.valid && (alu_req.op == ASP_OP_ADD);
    wire is_sub = alu_req.valid && (alu_req.op == ASP_OP_SUB);
    wire is_rlc = alu_req.valid && (alu_req.op == ASP_OP_RLC);
    wire is_rrc = alu_req.valid && (alu_req.op == ASP_OP_RRC);
    wire is_arith = is_add || is_sub;
    wire sets_zero = alu_req.valid && !is_rlc && !is_rrc; // rotates touch only carry
    wire carry_in = arith_status[ASP_C_BIT];
    // subtraction adds the two's complement of b as inverted b plus a carry in,
    // so the carry reads no borrow when b is zero, the nibble carry when its low nibble is zero
    wire [7:0] b_op = is_sub ? ~alu_req.b : alu_req.b; // [RQ8]
    wire [8:0] sum9 = {1'b0, alu_req.a} + {1'b0, b_op} + {8'h00, is_sub}; // [RQ8]
    wire [4:0] nib5 = {1'b0, alu_req.a[3:0]} + {1'b0, b_op[3:0]} + {4'h0, is_sub};
    logic [7:0] result;

    // result selection
    always_comb begin
        unique case (alu_req.op)
            ASP_OP_ADD, ASP_OP_SUB: result = sum9[7:0];
            ASP_OP_AND: result = alu_req.a & alu_req.b;
            ASP_OP_OR: result = alu_req.a | alu_req.b;
            ASP_OP_XOR: result = alu_req.a ^ alu_req.b;
            ASP_OP_MOV: result = alu_req.a;
            ASP_OP_RLC: result = {alu_req.a[6:0], carry_in};
            ASP_OP_RRC: result = {carry_in, alu_req.a[7:1]};
        endcase
    end

    // signed overflow: operands share a sign that the result lost
    wire ov_new = (alu_req.a[7] == b_op[7]) && (result[7] != alu_req.a[7]); // [RQ3]
    // carry set means carry out, or for subtraction no borrow
    wire c_new = sum9[8]; // [RQ6] [RQ7]
    wire dc_new = nib5[4]; // [RQ5] [RQ7]
    wire rot_c = is_rlc ? alu_req.a[7] : alu_req.a[0]; // [RQ9]

    // status next value: software first, then hardware flag updates win
    logic [7:0] next_status;
    always_comb begin
        next_status = arith_status;
        if (wr_status) begin
            next_status = w_data[7:0];
        end
        if (is_arith) begin
            next_status[ASP_OV_BIT] = ov_new; // [RQ3]
            next_status[ASP_DC_BIT] = dc_new; // [RQ5] [RQ7]
            next_status[ASP_C_BIT] = c_new; // [RQ6] [RQ7]
        end
        if (sets_zero) begin
            next_status[ASP_Z_BIT] = (result == 8'h00); // [RQ4]
        end
        if (is_rlc || is_rrc) begin
            next_status[ASP_C_BIT] = rot_c; // [RQ9]
        end
    end

    // status register and registered alu answer
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arith_status <= ASP_STATUS_RST;
            alu_rsp <= '0;
        end else begin
            arith_status <= next_status;
            alu_rsp.valid <= alu_req.valid;
            if (alu_req.valid) begin
                alu_rsp.data <= result;
            end
        end
    end

    // ---------------- pointer stepping ----------------
    wire [1:0] mode0 = arith_status[ASP_PTR0_MODE_LSB +: 2]; // [RQ2]
    wire [1:0] mode1 = arith_status[ASP_PTR1_MODE_LSB +: 2]; // [RQ1]
    logic [7:0] ptr_q [2];
    logic [7:0] next_ptr [2];
    wire [1:0] ptr_mode [2];
    wire ptr_wr [2];
    assign ptr_mode[0] = mode0;
    assign ptr_mode[1] = mode1;
    assign ptr_wr[0] = wr_ptr0;
    assign ptr_wr[1] = wr_ptr1;

    // one stepper per pointer; software load wins over a step
    for (genvar i = 0; i < 2; i++) begin : g_ptr
        always_comb begin
            next_ptr[i] = ptr_q[i];
            if (ptr_wr[i]) begin
                next_ptr[i] = w_data[7:0];
            end else if (ptr_access_done[i]) begin // [RQ10]
                if (ptr_mode[i] == ASP_STEP_DEC) begin
                    next_ptr[i] = ptr_q[i] - 8'h01; // [RQ1] [RQ2]
                end else if (ptr_mode[i] == ASP_STEP_INC) begin
                    next_ptr[i] = ptr_q[i] + 8'h01; // [RQ1] [RQ2]
                end
            end
        end
        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                ptr_q[i] <= ASP_PTR_RST;
            end else begin
                ptr_q[i] <= next_ptr[i];
            end
        end
    end
    assign indirect_pointer_zero = ptr_q[0];
    assign indirect_pointer_one = ptr_q[1];

    // ---------------- checks ----------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // helper sums recomputed independently of the datapath
    wire [8:0] chk_add9 = {1'b0, alu_req.a} + {1'b0, alu_req.b};
    wire [4:0] chk_nib5 = {1'b0, alu_req.a[3:0]} + {1'b0, alu_req.b[3:0]};

    ptr1_step_a: assert property (ptr_access_done[1] && !wr_ptr1 && mode1 == 2'h0 // [RQ1]
        |=> indirect_pointer_one == $past(indirect_pointer_one) - 8'h01)
        else $error("pointer one did not decrement");
    ptr0_step_a: assert property (ptr_access_done[0] && !wr_ptr0 && mode0 == 2'h1 // [RQ2]
        |=> indirect_pointer_zero == $past(indirect_pointer_zero) + 8'h01)
        else $error("pointer zero did not increment");
    ovf_flag_a: assert property (is_add // [RQ3]
        |=> arith_status[3] == ($past(alu_req.a[7]) == $past(alu_req.b[7])
            && alu_rsp.data[7] != $past(alu_req.a[7])))
        else $error("signed overflow flag wrong");
    zero_flag_a: assert property (sets_zero |=> alu_rsp.valid // [RQ4]
        && arith_status[2] == (alu_rsp.data == 8'h00))
        else $error("zero flag wrong");
    nibble_carry_a: assert property (is_add ##1 1'b1 // [RQ5]
        |-> arith_status[1] == $past(chk_nib5[4]))
        else $error("nibble carry wrong after add");
    add_carry_a: assert property (is_add |=> arith_status[0] == $past(chk_add9[8])) // [RQ6]
        else $error("carry wrong after add");
    borrow_pol_a: assert property (is_sub // [RQ7]
        |=> arith_status[0] == ($past(alu_req.a) >= $past(alu_req.b)))
        else $error("borrow polarity wrong");
    sub_twos_a: assert property (is_sub // [RQ8]
        |=> alu_rsp.data == 8'($past(alu_req.a) - $past(alu_req.b)))
        else $error("subtraction result wrong");
    rot_carry_a: assert property ((is_rlc || is_rrc) |=> arith_status[0] // [RQ9]
        == ($past(is_rlc) ? $past(alu_req.a[7]) : $past(alu_req.a[0])))
        else $error("rotate carry wrong");
    ptr_hold_a: assert property (!ptr_access_done[0] && !wr_ptr0 // [RQ10]
        |=> $stable(indirect_pointer_zero))
        else $error("pointer zero moved without access");
    // subtraction: nibble flag set means no borrow out of the low nibble
    nib_borrow_a: assert property (is_sub // [RQ7]
        |=> arith_status[1] == ($past(alu_req.a[3:0]) >= $past(alu_req.b[3:0])))
        else $error("nibble borrow polarity wrong");
    // subtraction: operands of opposite sign and result sign lost
    sub_ovf_a: assert property (is_sub // [RQ3]
        |=> arith_status[3] == ($past(alu_req.a[7]) != $past(alu_req.b[7])
            && alu_rsp.data[7] != $past(alu_req.a[7])))
        else $error("signed overflow wrong after subtract");
    // remaining step codes: the other direction on each pointer, hold on pointer one only
    ptr1_inc_a: assert property (ptr_access_done[1] && !wr_ptr1 && mode1 == 2'h1 // [RQ1]
        |=> indirect_pointer_one == $past(indirect_pointer_one) + 8'h01)
        else $error("pointer one did not increment");
    ptr0_dec_a: assert property (ptr_access_done[0] && !wr_ptr0 && mode0 == 2'h0 // [RQ2]
        |=> indirect_pointer_zero == $past(indirect_pointer_zero) - 8'h01)
        else $error("pointer zero did not decrement");
    ptr1_hold_a: assert property (ptr_access_done[1] && !wr_ptr1 && mode1[1] // [RQ1]
        |=> $stable(indirect_pointer_one))
        else $error("pointer one moved in hold mode");

    // main scenarios
    cov_sub_borrow: cover property (is_sub && alu_req.a < alu_req.b);
    cov_ptr_dec: cover property (ptr_access_done[1] && mode1 == 2'h0);
    cov_bus_write: cover property (wr_status ##1 s_axi_bvalid);
    cov_rotate: cover property (is_rrc ##1 alu_rsp.valid);
    cov_sub_nibble: cover property (is_sub && alu_req.b[3:0] == 4'h0 && alu_req.b != 8'h00);

endmodule : asp_core

/* File: verif/asp_core_tb.sv */
// Purpose: self-checking bench for asp_core flags, pointer steps and register access
// Assumes: asp_pkg constants, one 200 MHz clock, bench drives every port itself
// Notes: integer model of status and pointers compared with the design at each result
module asp_core_tb
    import asp_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    // clock, reset and bus signals, all idle at time zero
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata;
    logic [3:0] wstrb = 4'h0;
    logic [1:0] bresp, rresp;
    // core side
    asp_alu_req_t req = '0;
    asp_alu_rsp_t rsp;
    logic [1:0] pdone = 2'h0;
    logic [7:0] p0, p1, st_o;
    // bookkeeping and model state
    int failures = 0;
    int checked = 0;
    int st = 'hF0;
    int er = 0;

    // 200 MHz clock
    always #2.5 aclk = ~aclk;

    asp_core u_dut (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .alu_req(req), .alu_rsp(rsp),
        .ptr_access_done(pdone), .indirect_pointer_zero(p0),
        .indirect_pointer_one(p1), .arith_status(st_o)
    );

    // one comparison, reported at once on mismatch
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // axi write, address and data offered together, response awaited
    task automatic axw(input logic [7:0] ad, input logic [31:0] d, input logic [1:0] er_r);
        awaddr <= ad;
        wdata <= d;
        wstrb <= 4'hF;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        // only the watchdog ends a wait for the response
        do begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (!(bvalid && bready));
        bready <= 1'b0;
        chk(32'(bresp), 32'(er_r));
        // one edge passes so a following write never re-raises bready in this step
        @(posedge aclk);
    endtask : axw

    // axi read, data and response taken at the handshake edge
    task automatic axr(input logic [7:0] ad, input logic [31:0] ed, input logic [1:0] er_r);
        araddr <= ad;
        arvalid <= 1'b1;
        rready <= 1'b1;
        // only the watchdog ends a wait for the data
        do begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
        end while (!(rvalid && rready));
        rready <= 1'b0;
        chk(rdata, ed);
        chk(32'(rresp), 32'(er_r));
    endtask : axr

    // flag and result model of one operation
    function automatic void model(input int op, input int a, input int b);
        int r, bb, c, dc, ov;
        c = st & 1;
        bb = (op == 1) ? (~b & 255) : b; // subtract adds the complement
        r = 0;
        case (op)
            0, 1: begin
                r = a + bb + op;
                dc = ((a & 15) + (bb & 15) + op) > 15; // nibble carry
                ov = (((a ^ bb) & 128) == 0) && (((a ^ r) & 128) != 0);
                st = (st & 'hF0) | (ov << 3) | (((r & 255) == 0) << 2) | (dc << 1) | (r >> 8);
            end
            6: begin
                r = ((a << 1) & 255) | c;
                st = (st & 'hFE) | (a >> 7); // shifted-out high bit
            end
            7: begin
                r = (a >> 1) | (c << 7);
                st = (st & 'hFE) | (a & 1); // shifted-out low bit
            end
            default: begin
                r = (op == 2) ? (a & b) : (op == 3) ? (a | b) : (op == 4) ? (a ^ b) : a;
                st = (st & 'hFB) | ((r == 0) << 2); // zero only
            end
        endcase
        er = r & 255;
    endfunction : model

    // pointer after two steps from 0x80 for a mode code
    function automatic int stp(input int m);
        return (m == 0) ? 'h7E : (m == 1) ? 'h82 : 'h80;
    endfunction : stp

    // verdict and end of run
    task automatic end_sim;
        $display("compared %0d mismatches %0d", checked, failures);
        if (failures == 0 && checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : end_sim

    // watchdog against a hung handshake
    initial begin
        #20000;
        failures++;
        end_sim();
    end

    // main sequence
    initial begin
        int i, m, op, a, b;
        logic v, pv;
        pv = 1'b0;
        void'($urandom(21063));
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        chk(32'(st_o), 32'hF0);
        chk(32'({p1, p0}), 32'h0);
        axr(ASP_STATUS_OFFS, 32'hF0, ASP_RESP_OKAY);
        $display("test reset done");
        // random back-to-back operations with idle gaps
        for (i = 0; i < 400; i++) begin
            @(posedge aclk);
            v = ($urandom_range(0, 3) != 0);
            op = $urandom_range(0, 7);
            a = $urandom & ($urandom_range(0, 1) ? 'hFF : 'h81);
            b = $urandom & ($urandom_range(0, 1) ? 'hFF : 'h81);
            req <= '{v, asp_op_t'(op), 8'(a), 8'(b)};
            #1;
            chk(32'(rsp.valid), 32'(pv));
            if (pv) chk(32'(rsp.data), er);
            chk(32'(st_o), st);
            pv = v;
            if (v) model(op, a, b);
        end
        @(posedge aclk);
        req <= '0;
        @(posedge aclk);
        axr(ASP_STATUS_OFFS, 32'(st), ASP_RESP_OKAY);
        $display("test alu done");
        // every step code on both pointers, idle cycles between
        for (m = 0; m < 4; m++) begin
            st = (m << 6) | ((3 - m) << 4);
            axw(ASP_STATUS_OFFS, 32'(st), ASP_RESP_OKAY);
            axr(ASP_STATUS_OFFS, 32'(st), ASP_RESP_OKAY);
            axw(ASP_PTR0_OFFS, 32'h80, ASP_RESP_OKAY);
            axw(ASP_PTR1_OFFS, 32'h80, ASP_RESP_OKAY);
            chk(32'({p1, p0}), 32'h8080); // no access, no step
            pdone <= 2'h3;
            repeat (2) @(posedge aclk);
            pdone <= 2'h0;
            repeat (3) @(posedge aclk);
            chk(32'(p1), stp(m));
            chk(32'(p0), stp(3 - m));
            axr(ASP_PTR0_OFFS, 32'(stp(3 - m)), ASP_RESP_OKAY);
        end
        $display("test pointer done");
        // unmapped place refused
        axw(8'h10, 32'hA5, ASP_RESP_SLVERR);
        axr(8'h10, 32'h0, ASP_RESP_SLVERR);
        $display("test unmapped done");
        end_sim();
    end
endmodule : asp_core_tb
